// >>> rtl/pdc_regs.svh
/*
 * Field positions, control codes, reset values and limits of the divider
 * configuration words. Included by bare name; definitions only.
 */
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH

// ----------------------------------------------------------------
// Serial word framing
// ----------------------------------------------------------------
`define PDC_WORD_W 24
`define PDC_BITS_FULL 5'h18
`define PDC_CTRL_REF 4'h3
`define PDC_CTRL_AUX 4'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PDC_MAIN_N_MSB 23
`define PDC_MAIN_N_LSB 13
`define PDC_REF_PD_BIT 23
`define PDC_REF_P_BIT 22
`define PDC_REF_R_MSB 21
`define PDC_REF_R_LSB 16
`define PDC_AUX_PD_BIT 23
`define PDC_AUX_N_MSB 22
`define PDC_AUX_N_LSB 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDC_RST_MAIN_N 11'h000
`define PDC_RST_REF_R 6'h01
`define PDC_RST_P 1'b0
`define PDC_RST_MAIN_PD 1'b1
`define PDC_RST_AUX_N 19'h00000
`define PDC_RST_AUX_PD 1'b1

// ----------------------------------------------------------------
// Divide limits
// ----------------------------------------------------------------
`define PDC_P1_MIN 11'h061
`define PDC_P1_MAX 11'h7fd
`define PDC_P1_GAP_LO 11'h0e3
`define PDC_P1_GAP_HI 11'h0e6
`define PDC_P0_MIN 11'h031
`define PDC_P0_MAX 11'h3ff
`define PDC_AUX8_LAST_BAD 19'h00017
`define PDC_AUX16_LAST_BAD 19'h0002f

`endif

// >>> rtl/pdc_pkg.sv
/*
 * Types shared by the divider configuration block.
 * Assumes the constants header is included where numbers are needed.
 */
package pdc_pkg;

    typedef logic [23:0] pdc_word_t;

    // Modulator order as delivered by the synthesizer core
    typedef enum logic [1:0] {
        pdc_ord_int = 2'h0,
        pdc_ord_2nd = 2'h1,
        pdc_ord_3rd = 2'h2,
        pdc_ord_4th = 2'h3
    } pdc_order_t;

endpackage

// >>> rtl/pdc_word_if.sv
/*
 * Carrier for complete serial words from the shifter to the register bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns

interface pdc_word_if;
    pdc_pkg::pdc_word_t word;
    logic word_valid;

    modport src (output word, output word_valid);
    modport snk (input word, input word_valid);
endinterface

// >>> rtl/pdc_shift.sv
/*
 * Three-wire serial shifter: MSB first on serial clock rise, word handed on
 * at latch rise. Assumes pins are already synchronous to mclk.
 */
`timescale 1ns/1ns
`include "pdc_regs.svh"

module pdc_shift
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    pdc_word_if.src out
);

    // ----------------------------------------------------------------
    // Shift state
    // ----------------------------------------------------------------
    logic [23:0] shreg;
    logic [23:0] next_shreg;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic clk_d;
    logic latch_d;
    logic [23:0] word_q;
    logic [23:0] next_word_q;
    logic valid_q;
    logic next_valid_q;

    always_comb
    begin
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        next_word_q = word_q;
        next_valid_q = 1'b0;
        // Latch edge wins over a coincident clock edge
        if (ser_latch && !latch_d)
        begin
            if (bit_cnt == `PDC_BITS_FULL) // R17
            begin
                next_word_q = shreg;
                next_valid_q = 1'b1;
            end
            next_bit_cnt = 5'h00;
        end
        else if (ser_clk && !clk_d)
        begin
            next_shreg = {shreg[22:0], ser_data};
            if (bit_cnt != `PDC_BITS_FULL)
            begin
                next_bit_cnt = bit_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            shreg <= 24'h000000;
            bit_cnt <= 5'h00;
            clk_d <= 1'b0;
            latch_d <= 1'b0;
            word_q <= 24'h000000;
            valid_q <= 1'b0;
        end
        else if (clk_en)
        begin
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            clk_d <= ser_clk;
            latch_d <= ser_latch;
            word_q <= next_word_q;
            valid_q <= next_valid_q;
        end
    end

    assign out.word = word_q;
    assign out.word_valid = valid_q;

endmodule // pdc_shift

// >>> rtl/pdc_top.sv
/*
 * Main and auxiliary divider configuration bank fed by a three-wire serial
 * port, with power-down precedence. Assumes synchronous pins and that the
 * modulator order, auto power-up and aux prescaler select come from the core.
 */
// Overview of operation
// R1 - Larger prescaler: divide word splits 6/3/2; legal 97 to 2045.
// R2 - Host avoids 227-230 with fourth order modulator and larger prescaler.
// R3 - Reference divider divides by its 6-bit word, 1 to 63.
// R4 - Prescaler select 0 picks 16/17/20/21, 1 picks 32/33/36/37.
// R5 - Main power-down 0 without override: main loop runs.
// R6 - Main power-down 1 without override: loop off, charge pump floats.
// R7 - Chip enable low forces main loop down above everything.
// R8 - Chip enable high and auto power-up: main loop up regardless.
// R9 - Otherwise main power-down bit decides.
// R10 - 8/9 aux prescaler: low 3 bits swallow; up to 23 prohibited.
// R11 - 16/17 aux prescaler: low 4 bits swallow; up to 47 prohibited.
// R12 - Host uses only listed low aux values; higher values all legal.
// R13 - Main ratio is modulus times cycle plus four middle plus low.
// R14 - Aux power-down 0 runs aux loop; 1 stops it, pump floats.
// R15 - Auto power-up and main divide write clear aux power-down.
// R16 - Low control bits 0011 and 0101 route words to their registers.
// R17 - Settings change only after a whole latched 24-bit word.
`timescale 1ns/1ns
`include "pdc_regs.svh"

module pdc_top
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    input wire logic chip_enable,
    input wire logic auto_power_up,
    input wire logic aux_prescaler_select,
    input wire pdc_pkg::pdc_order_t modulator_order,
    output logic [10:0] main_feedback_divide,
    output logic [5:0] main_cycle_count,
    output logic [2:0] main_middle_count,
    output logic [1:0] main_low_count,
    output logic [11:0] main_divide_ratio,
    output logic main_divide_legal,
    output logic main_prescaler_select,
    output logic [5:0] main_reference_divide,
    output logic main_loop_on,
    output logic main_cp_hiz,
    output logic [18:0] aux_divide,
    output logic [15:0] aux_main_count,
    output logic [3:0] aux_swallow_count,
    output logic aux_divide_legal,
    output logic aux_loop_on,
    output logic aux_cp_hiz
);

    // ----------------------------------------------------------------
    // Serial front end
    // ----------------------------------------------------------------
    pdc_word_if word_bus ();

    pdc_shift u_shift
    (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_latch(ser_latch),
        .out(word_bus.src)
    );

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [10:0] main_n;
    logic [10:0] next_main_n;
    logic [5:0] ref_r;
    logic [5:0] next_ref_r;
    logic presc_p;
    logic next_presc_p;
    logic main_power_down;
    logic next_main_power_down;
    logic [18:0] aux_n;
    logic [18:0] next_aux_n;
    logic aux_power_down;
    logic next_aux_power_down;
    pdc_pkg::pdc_word_t w;

    always_comb
    begin
        w = word_bus.word;
        next_main_n = main_n;
        next_ref_r = ref_r;
        next_presc_p = presc_p;
        next_main_power_down = main_power_down;
        next_aux_n = aux_n;
        next_aux_power_down = aux_power_down;
        if (word_bus.word_valid) // R17
        begin
            // Main divide word is the only one flagged by a clear bit 0
            if (!w[0])
            begin
                next_main_n = w[`PDC_MAIN_N_MSB:`PDC_MAIN_N_LSB];
                if (auto_power_up)
                begin
                    next_aux_power_down = 1'b0; // R15
                end
            end
            else if (w[3:0] == `PDC_CTRL_REF) // R16
            begin
                next_main_power_down = w[`PDC_REF_PD_BIT];
                next_presc_p = w[`PDC_REF_P_BIT];
                next_ref_r = w[`PDC_REF_R_MSB:`PDC_REF_R_LSB];
            end
            else if (w[3:0] == `PDC_CTRL_AUX) // R16
            begin
                next_aux_power_down = w[`PDC_AUX_PD_BIT];
                next_aux_n = w[`PDC_AUX_N_MSB:`PDC_AUX_N_LSB];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            main_n <= `PDC_RST_MAIN_N;
            ref_r <= `PDC_RST_REF_R;
            presc_p <= `PDC_RST_P;
            main_power_down <= `PDC_RST_MAIN_PD;
            aux_n <= `PDC_RST_AUX_N;
            aux_power_down <= `PDC_RST_AUX_PD;
        end
        else if (clk_en)
        begin
            main_n <= next_main_n;
            ref_r <= next_ref_r;
            presc_p <= next_presc_p;
            main_power_down <= next_main_power_down;
            aux_n <= next_aux_n;
            aux_power_down <= next_aux_power_down;
        end
    end

    // ----------------------------------------------------------------
    // Derived divider and power outputs
    // ----------------------------------------------------------------
    logic [11:0] next_ratio;
    logic next_main_legal;
    logic [15:0] next_aux_main;
    logic [3:0] next_aux_swallow;
    logic next_aux_legal;
    logic next_main_on;
    logic next_aux_on;

    always_comb
    begin
        // R13: shift by 5 or 4 stands for the 32 or 16 base modulus
        next_ratio = (presc_p ? {1'b0, main_n[10:5], 5'h00} : {2'h0, main_n[10:5], 4'h0})
            + {7'h00, main_n[4:2], 2'h0} + {10'h000, main_n[1:0]};
        if (presc_p) // R4
        begin
            next_main_legal = (main_n >= `PDC_P1_MIN) && (main_n <= `PDC_P1_MAX) // R1
                && !((modulator_order == pdc_pkg::pdc_ord_4th)
                && (main_n >= `PDC_P1_GAP_LO) && (main_n <= `PDC_P1_GAP_HI)); // R2
        end
        else
        begin
            next_main_legal = (main_n >= `PDC_P0_MIN) && (main_n <= `PDC_P0_MAX);
        end
        if (aux_prescaler_select)
        begin
            next_aux_swallow = aux_n[3:0]; // R11
            next_aux_main = {1'b0, aux_n[18:4]};
            next_aux_legal = aux_n > `PDC_AUX16_LAST_BAD;
        end
        else
        begin
            next_aux_swallow = {1'b0, aux_n[2:0]}; // R10
            next_aux_main = aux_n[18:3];
            next_aux_legal = aux_n > `PDC_AUX8_LAST_BAD;
        end
        // Chip enable first, then auto power-up, then the bit itself
        next_main_on = chip_enable && (auto_power_up || !main_power_down); // R5 R6 R7 R8 R9
        next_aux_on = chip_enable && !aux_power_down; // R14 R15
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            main_feedback_divide <= `PDC_RST_MAIN_N;
            main_cycle_count <= 6'h00;
            main_middle_count <= 3'h0;
            main_low_count <= 2'h0;
            main_divide_ratio <= 12'h000;
            main_divide_legal <= 1'b0;
            main_prescaler_select <= `PDC_RST_P;
            main_reference_divide <= `PDC_RST_REF_R;
            main_loop_on <= 1'b0;
            main_cp_hiz <= 1'b1;
            aux_divide <= `PDC_RST_AUX_N;
            aux_main_count <= 16'h0000;
            aux_swallow_count <= 4'h0;
            aux_divide_legal <= 1'b0;
            aux_loop_on <= 1'b0;
            aux_cp_hiz <= 1'b1;
        end
        else if (clk_en)
        begin
            main_feedback_divide <= main_n;
            main_cycle_count <= main_n[10:5]; // R1
            main_middle_count <= main_n[4:2];
            main_low_count <= main_n[1:0];
            main_divide_ratio <= next_ratio;
            main_divide_legal <= next_main_legal;
            main_prescaler_select <= presc_p; // R4
            main_reference_divide <= ref_r; // R3
            main_loop_on <= next_main_on;
            main_cp_hiz <= !next_main_on; // R6
            aux_divide <= aux_n;
            aux_main_count <= next_aux_main;
            aux_swallow_count <= next_aux_swallow;
            aux_divide_legal <= next_aux_legal; // R12
            aux_loop_on <= next_aux_on;
            aux_cp_hiz <= !next_aux_on; // R14
        end
    end

endmodule // pdc_top

// >>> tb/pdc_monitor.sv
/* Concurrent checks on the divider bank's output ports.
   Bound to pdc_top; sees its ports only, one clock domain. */
`timescale 1ns/1ns
module pdc_monitor
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic chip_enable,
    input wire logic auto_power_up,
    input wire logic aux_prescaler_select,
    input wire pdc_pkg::pdc_order_t modulator_order,
    input wire logic [10:0] main_feedback_divide,
    input wire logic [5:0] main_cycle_count,
    input wire logic [2:0] main_middle_count,
    input wire logic [1:0] main_low_count,
    input wire logic [11:0] main_divide_ratio,
    input wire logic main_divide_legal,
    input wire logic main_prescaler_select,
    input wire logic main_loop_on,
    input wire logic main_cp_hiz,
    input wire logic [18:0] aux_divide,
    input wire logic [3:0] aux_swallow_count,
    input wire logic aux_divide_legal,
    input wire logic aux_loop_on,
    input wire logic aux_cp_hiz
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_hiz;
        main_cp_hiz == !main_loop_on && aux_cp_hiz == !aux_loop_on;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pump float mismatch");
    property p_ce;
        !chip_enable |=> !main_loop_on && !aux_loop_on;
    endproperty
    a_ce: assert property (p_ce) else $error("loop on without enable");
    property p_apu;
        chip_enable && auto_power_up |=> main_loop_on;
    endproperty
    a_apu: assert property (p_apu) else $error("auto power-up ignored");
    property p_aon;
        aux_loop_on |-> $past(chip_enable);
    endproperty
    a_aon: assert property (p_aon) else $error("aux on without enable");
    property p_split;
        main_cycle_count == main_feedback_divide[10:5]
            && main_middle_count == main_feedback_divide[4:2]
            && main_low_count == main_feedback_divide[1:0];
    endproperty
    a_split: assert property (p_split) else $error("main split wrong");
    property p_ratio;
        main_divide_ratio == (main_prescaler_select ? 32 : 16) * main_cycle_count
            + 4 * main_middle_count + main_low_count;
    endproperty
    a_ratio: assert property (p_ratio) else $error("main ratio wrong");
    // Order input reaches the flag a cycle late, so only judge settled values
    property p_legal;
        main_prescaler_select && $stable(main_prescaler_select)
            && $stable(main_feedback_divide) && $stable(modulator_order)
            |-> main_divide_legal == (main_feedback_divide >= 11'h061
            && main_feedback_divide <= 11'h7fd && !(modulator_order == pdc_pkg::pdc_ord_4th
            && main_feedback_divide >= 11'h0e3 && main_feedback_divide <= 11'h0e6));
    endproperty
    a_legal: assert property (p_legal) else $error("main legal flag wrong");
    property p_aux;
        $stable(aux_prescaler_select) |-> aux_swallow_count == (aux_prescaler_select
            ? aux_divide[3:0] : {1'b0, aux_divide[2:0]}) && aux_divide_legal
            == (aux_divide > (aux_prescaler_select ? 19'h0002f : 19'h00017));
    endproperty
    a_aux: assert property (p_aux) else $error("aux split or flag wrong");
endmodule // pdc_monitor

// >>> tb/pdc_host.sv
/* Host model for the three-wire serial port.
   Assumes a free-running mclk; pins move 1 ns after its rise. */
`timescale 1ns/1ns
module pdc_host
(
    input wire logic mclk,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_latch
);
    initial
    begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b0;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // Top n bits of w, MSB first, then latch; n below 24 makes a torn word
    task automatic send(input pdc_pkg::pdc_word_t w, input int n);
        for (int i = 23; i > 23 - n; i--)
        begin
            ser_data = w[i];
            ser_clk = 1'b0;
            tick(2);
            ser_clk = 1'b1;
            tick(2);
        end
        ser_clk = 1'b0;
        // No stale level left on the released data line
        ser_data = ~ser_data;
        tick(2);
        ser_latch = 1'b1;
        tick(2);
        ser_latch = 1'b0;
        // Word reaches the outputs three mclk edges after the latch rise
        tick(2);
    endtask
endmodule // pdc_host

// >>> tb/pdc_top_tb.sv
/* Self-checking bench of the divider configuration bank.
   Drives pins 1 ns after mclk rise; the host model shifts words in. */
`timescale 1ns/1ns
module pdc_top_tb;
    typedef struct {pdc_pkg::pdc_word_t w; logic ok;} pdc_row_t;
    logic mclk, rst, ce, apu, asel, ser_clk, ser_data, ser_latch, en;
    pdc_pkg::pdc_order_t ord;
    logic [10:0] main_feedback_divide;
    logic [11:0] main_divide_ratio;
    logic [5:0] main_reference_divide;
    logic [3:0] aux_swallow_count;
    logic [15:0] aux_main_count;
    logic main_divide_legal, main_prescaler_select, main_loop_on, main_cp_hiz;
    logic aux_divide_legal, aux_loop_on;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    pdc_row_t rows [9] = '{
        '{24'h0c0000, 1'b0}, '{24'h0c2000, 1'b1},
        '{24'h1c6000, 1'b0},
        '{24'h1ce000, 1'b1}, '{24'hffa000, 1'b1}, '{24'hffc000, 1'b0},
        '{24'h000175, 1'b0}, '{24'h000185, 1'b1},
        '{24'h3ffff5, 1'b1}};
    pdc_host u_host (.mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
    pdc_top dut (.mclk(mclk), .rst(rst), .clk_en(en), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_latch(ser_latch), .chip_enable(ce), .auto_power_up(apu),
        .aux_prescaler_select(asel), .modulator_order(ord),
        .main_feedback_divide(main_feedback_divide), .main_cycle_count(),
        .main_middle_count(), .main_low_count(), .main_divide_ratio(main_divide_ratio),
        .main_divide_legal(main_divide_legal), .main_prescaler_select(main_prescaler_select),
        .main_reference_divide(main_reference_divide), .main_loop_on(main_loop_on),
        .main_cp_hiz(main_cp_hiz), .aux_divide(), .aux_main_count(aux_main_count),
        .aux_swallow_count(aux_swallow_count), .aux_divide_legal(aux_divide_legal),
        .aux_loop_on(aux_loop_on), .aux_cp_hiz());
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude;
        if (err_total == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            conclude;
        end
    end
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        en = 1'b1;
        apu = 1'b0;
        asel = 1'b0;
        ord = pdc_pkg::pdc_ord_4th;
        tick(10);
        rst = 1'b0;
        tick(1);
        chk("ref_reset", 6'h01, main_reference_divide);
        u_host.send(24'hff0003, 24);
        chk("ref", 6'h3f, main_reference_divide);
        chk("psel", 1'b1, main_prescaler_select);
        chk("main_on", 1'b0, main_loop_on);
        chk("main_hiz", 1'b1, main_cp_hiz);
        apu = 1'b1;
        tick(2);
        chk("main_on", 1'b1, main_loop_on);
        apu = 1'b0;
        u_host.send(24'h7f0003, 24);
        chk("main_on", 1'b1, main_loop_on);
        foreach (rows[i])
        begin
            u_host.send(rows[i].w, 24);
            if (rows[i].w[0] == 1'b0)
            begin
                chk("main_n", rows[i].w[23:13], main_feedback_divide);
                chk("ratio", rows[i].w[23:13], main_divide_ratio);
                chk("main_legal", rows[i].ok, main_divide_legal);
            end
            else
                chk("aux_legal", rows[i].ok, aux_divide_legal);
        end
        chk("aux_on", 1'b1, aux_loop_on);
        chk("aux_main", 16'h7fff, aux_main_count);
        chk("swallow", 4'h7, aux_swallow_count);
        // Torn word, then unknown code: both must leave the setting alone
        u_host.send(24'h450003, 23);
        chk("ref", 6'h3f, main_reference_divide);
        u_host.send(24'h450007, 24);
        chk("ref", 6'h3f, main_reference_divide);
        asel = 1'b1;
        u_host.send(24'h8002f5, 24);
        chk("aux_legal", 1'b0, aux_divide_legal);
        chk("swallow", 4'hf, aux_swallow_count);
        chk("aux_main", 16'h0002, aux_main_count);
        chk("aux_on", 1'b0, aux_loop_on);
        apu = 1'b1;
        u_host.send(24'h1ce000, 24);
        chk("aux_on", 1'b1, aux_loop_on);
        // Second order modulator may use 227 with the larger prescaler
        ord = pdc_pkg::pdc_ord_2nd;
        u_host.send(24'h1c6000, 24);
        chk("main_legal", 1'b1, main_divide_legal);
        // Frozen clock enable: a whole word sent meanwhile is lost
        en = 1'b0;
        u_host.send(24'h410003, 24);
        en = 1'b1;
        tick(2);
        chk("ref", 6'h3f, main_reference_divide);
        // Smaller prescaler: ratio is 16 per cycle count
        u_host.send(24'h3f0003, 24);
        chk("psel", 1'b0, main_prescaler_select);
        u_host.send(24'h0c8000, 24);
        chk("ratio", 12'h034, main_divide_ratio);
        chk("main_legal", 1'b1, main_divide_legal);
        ce = 1'b0;
        tick(2);
        chk("main_on", 1'b0, main_loop_on);
        chk("aux_on", 1'b0, aux_loop_on);
        conclude;
    end
endmodule // pdc_top_tb

bind pdc_top pdc_monitor u_mon (.mclk(mclk), .rst(rst), .chip_enable(chip_enable),
    .auto_power_up(auto_power_up), .aux_prescaler_select(aux_prescaler_select),
    .modulator_order(modulator_order), .main_feedback_divide(main_feedback_divide),
    .main_cycle_count(main_cycle_count), .main_middle_count(main_middle_count),
    .main_low_count(main_low_count), .main_divide_ratio(main_divide_ratio),
    .main_divide_legal(main_divide_legal), .main_prescaler_select(main_prescaler_select),
    .main_loop_on(main_loop_on), .main_cp_hiz(main_cp_hiz), .aux_divide(aux_divide),
    .aux_swallow_count(aux_swallow_count), .aux_divide_legal(aux_divide_legal),
    .aux_loop_on(aux_loop_on), .aux_cp_hiz(aux_cp_hiz));
